// ===== rtl/mita_pkg.sv
// Purpose: Shared constants for the monitor interrupt and thermal alarm block
// Assumes: Register index n sits at APB byte address 4*n
// Notes: Register reset values, configuration field positions and timing figures live here; mita_top packs the status bits itself
package mita_pkg;
  localparam int APB_AW = 12;
  // Register indices
  localparam logic [7:0] IDX_CFG1 = 8'h40;
  localparam logic [7:0] IDX_ST1 = 8'h41;
  localparam logic [7:0] IDX_ST2 = 8'h42;
  localparam logic [7:0] IDX_MSK1 = 8'h43;
  localparam logic [7:0] IDX_MSK2 = 8'h44;
  localparam logic [7:0] IDX_CFG2 = 8'h4a;
  localparam logic [7:0] IDX_MIR1 = 8'h4c;
  localparam logic [7:0] IDX_MIR2 = 8'h4d;
  localparam logic [7:0] IDX_ALERT = 8'h80;
  // Reset values
  localparam logic [7:0] RST_CFG1 = 8'h08;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ALERT = 8'h20;
  // Configuration fields
  localparam int C1_INT_EN = 1;
  localparam int C1_THERMAL_ALARM_N_EN = 2;
  localparam int C1_INT_CLR = 3;
  localparam int C1_RST_PULSE = 4;
  localparam int C1_THERMAL_ALARM_CLEAR = 6;
  localparam int C2_THERMAL_ALARM_N_MASK = 0;
  localparam int C2_ACPI = 3;
  localparam int AL_ENABLE = 6;
  // Temperature-related status bits, gated by the thermal mask
  localparam logic [7:0] THERMAL_BITS1 = 8'h30;
  localparam logic [7:0] THERMAL_BITS2 = 8'h30;
  localparam logic [7:0] ALL_ONES = 8'hff;
  // Channel counts and fault queue depth
  localparam int NUM_TEMP = 3;
  localparam int NUM_VF = 10;
  localparam int FAULT_DEPTH = 3;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int RST_PULSE_MS = 20;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = 3;
  localparam int STRAP_WAIT = 3;
  localparam logic [2:0] SYNC_RST = 3'b011;
  // Reset pin sequencer
  typedef enum logic [2:0] {
    RP_IDLE = 3'b001,
    RP_PULSE = 3'b010,
    RP_RECOVER = 3'b100
  } mita_rp_type;
endpackage

// ===== rtl/mita_top.sv
// Purpose: Interrupt, status and thermal alarm logic of a hardware monitor
// Assumes: Limit comparisons arrive with CONV_DONE_I on REF_CLK_I
// Notes: Registers over APB, one word each; alarm and reset pins as three wires, interrupt as two
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module mita_top #(
  parameter int RST_PULSE_CYCLES = mita_pkg::RST_PULSE_CYC,
  parameter int FAULT_DEPTH = mita_pkg::FAULT_DEPTH
) (
  input wire logic REF_CLK_I, // Device clock
  input wire logic RST_I, // Asynchronous reset, active high
  input wire logic CE_I, // Clock enable, freezes state when low
  input wire logic PSEL_I, // APB select
  input wire logic PENABLE_I, // APB enable
  input wire logic PWRITE_I, // APB direction
  input wire logic [mita_pkg::APB_AW-1:0] PADDR_I, // APB byte address
  input wire logic [31:0] PWDATA_I, // APB write data
  output logic [31:0] PRDATA_O, // APB read data
  output logic PREADY_O, // APB ready
  output logic PSLVERR_O, // APB error on unmapped address
  input wire logic CONV_DONE_I, // Conversion round completed pulse
  input wire logic [mita_pkg::NUM_VF-1:0] VF_OUT_I, // Voltage/fan out of limit
  input wire logic [mita_pkg::NUM_TEMP-1:0] TEMP_HI_I, // Above high limit
  input wire logic [mita_pkg::NUM_TEMP-1:0] TEMP_LO_I, // Below low limit
  input wire logic [mita_pkg::NUM_TEMP-1:0] TEMP_HW_I, // Above hw or 126
  input wire logic [mita_pkg::NUM_TEMP-1:0] TEMP_HW_OK_I, // 5 below hw
  input wire logic ARA_ACK_I, // Alert response address acknowledged
  input wire logic THERMAL_ALARM_N_I, // Alarm pin level
  output logic THERMAL_ALARM_N_O, // Alarm pin drive value
  output logic THERMAL_ALARM_N_OE_N_O, // Alarm pin enable, low drives
  output logic INT_N_O, // Interrupt pin drive value
  output logic INT_N_OE_N_O, // Interrupt pin enable, low drives
  input wire logic RESET_N_I, // Reset pin level
  output logic RESET_N_O, // Reset pin drive value
  output logic RESET_N_OE_N_O, // Reset pin enable, low drives
  input wire logic DAC_PIN_TREE_IN_I, // Tree test strap level
  output logic FAN_DAC_OUT_FULL_O, // Force fan output to full scale
  output logic LOOP_RUN_O, // Monitoring loop may run
  output logic ALERT_PENDING_O, // Device answers alert response
  output logic TREE_MODE_O // Tree test mode active
);
  import mita_pkg::*;

  localparam int FQW = $clog2(FAULT_DEPTH + 1);

  // Parameter checks
  if (FAULT_DEPTH < 1 || FAULT_DEPTH > 7) begin : g_bad_depth
    $error("FAULT_DEPTH out of range");
  end
  if (RST_PULSE_CYCLES < 1) begin : g_bad_pulse
    $error("RST_PULSE_CYCLES must be positive");
  end

  logic [7:0] cfg1_r, cfg2_r, msk1_r, msk2_r, alert_r, st1_r, st2_r;
  logic [7:0] cfg1_nxt, st1_nxt, st2_nxt;
  logic [2:0] sync1_r, sync2_r;
  logic drive_low_r;
  logic alarm_r, alarm_nxt;
  logic [1:0] alarm_d_r; // Own drive history, spans the synchroniser lag
  logic ext_low_d_r, hw_irq_r, hw_irq_nxt, ara_done_r;
  logic [NUM_TEMP-1:0] hw_hold_r, hw_hold_nxt;
  logic [FQW-1:0] fq_cnt_r [1:NUM_TEMP-1];
  logic [NUM_TEMP-1:0] qual;
  mita_rp_type rp_state_r, rp_state_nxt;
  logic [31:0] rp_cnt_r;
  logic [1:0] strap_cnt_r;
  logic tree_r, strap_done_r;

  // Pin synchronisers: alarm, reset pin, strap
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else if (CE_I) begin
      sync1_r <= {DAC_PIN_TREE_IN_I, RESET_N_I, THERMAL_ALARM_N_I};
      sync2_r <= sync1_r;
    end
  end

  wire alarm_pin_s = sync2_r[0];
  wire reset_pin_s = sync2_r[1];
  wire strap_s = sync2_r[2];

  // APB decode; only word aligned indices in the low 1 KiB hit
  wire [7:0] idx = PADDR_I[9:2];
  wire addr_ok = (PADDR_I[APB_AW-1:10] == '0) && (PADDR_I[1:0] == 2'b00);
  wire hit_cfg1 = addr_ok && idx == IDX_CFG1;
  wire hit_cfg2 = addr_ok && idx == IDX_CFG2;
  wire hit_st1 = addr_ok && idx == IDX_ST1;
  wire hit_st2 = addr_ok && idx == IDX_ST2;
  wire hit_msk1 = addr_ok && idx == IDX_MSK1;
  wire hit_msk2 = addr_ok && idx == IDX_MSK2;
  wire hit_mir1 = addr_ok && idx == IDX_MIR1;
  wire hit_mir2 = addr_ok && idx == IDX_MIR2;
  wire hit_alert = addr_ok && idx == IDX_ALERT;
  wire mapped = hit_cfg1 | hit_cfg2 | hit_st1 | hit_st2 | hit_msk1 |
    hit_msk2 | hit_mir1 | hit_mir2 | hit_alert;
  wire acc_first = PSEL_I & PENABLE_I & ~PREADY_O;
  wire acc_done = PSEL_I & PENABLE_I & PREADY_O;
  wire wr_ok = acc_done & PWRITE_I;
  wire rd_st1 = acc_done & ~PWRITE_I & hit_st1;
  wire rd_st2 = acc_done & ~PWRITE_I & hit_st2;
  wire [7:0] rd_byte = ({8{hit_cfg1}} & cfg1_r) |
    ({8{hit_cfg2}} & cfg2_r) |
    ({8{hit_st1 | hit_mir1}} & st1_r) |
    ({8{hit_st2 | hit_mir2}} & st2_r) |
    ({8{hit_msk1}} & msk1_r) | ({8{hit_msk2}} & msk2_r) |
    ({8{hit_alert}} & alert_r);

  // APB answer: one wait state so read data comes from a flop
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else if (CE_I) begin
      PREADY_O <= acc_first;
      PSLVERR_O <= acc_first & ~mapped;
      if (acc_first) begin
        PRDATA_O <= {24'h00_0000, PWRITE_I ? 8'h00 : rd_byte};
      end
    end
  end

  // Loop runs only while the line clear bit is low
  wire loop_run = ~cfg1_r[C1_INT_CLR];
  wire conv = CONV_DONE_I & loop_run;

  // Fault queue for external channels; internal channel passes straight
  assign qual[0] = 1'b1;
  for (genvar c = 1; c < NUM_TEMP; c++) begin : g_fq
    wire bad = TEMP_HI_I[c] | TEMP_LO_I[c] | TEMP_HW_I[c];
    wire [FQW-1:0] cnt_nxt = ~bad ? '0 :
      (fq_cnt_r[c] == FQW'(FAULT_DEPTH)) ? fq_cnt_r[c] :
      FQW'(fq_cnt_r[c] + 1'b1);
    assign qual[c] = (cnt_nxt == FQW'(FAULT_DEPTH));
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        fq_cnt_r[c] <= '0;
      end else if (CE_I && conv) begin
        fq_cnt_r[c] <= cnt_nxt;
      end
    end
  end

  wire [NUM_TEMP-1:0] hi_q = TEMP_HI_I & qual;
  wire [NUM_TEMP-1:0] lo_q = TEMP_LO_I & qual;
  wire [NUM_TEMP-1:0] hw_q = TEMP_HW_I & qual;
  wire [NUM_TEMP-1:0] t_q = hi_q | lo_q;

  // External alarm low, blind while driving and two cycles after release
  wire ext_low = ~alarm_pin_s & ~alarm_r & ~|alarm_d_r;
  wire thermal_alarm_n_set = ext_low & (~ext_low_d_r | conv);

  // Status set terms; masks play no part here
  wire [7:0] set1 = conv ? {VF_OUT_I[9:8], t_q[1], t_q[0], VF_OUT_I[3:0]}
    : 8'h00;
  wire [7:0] set2 = {2'b00, conv & t_q[2], thermal_alarm_n_set,
    conv ? VF_OUT_I[7:4] : 4'h0};
  // One good external reading drops its temperature bit
  wire [7:0] good1 = {2'b00, conv & ~(TEMP_HI_I[1] | TEMP_LO_I[1]), 5'h00};
  wire [7:0] good2 = {2'b00, conv & ~(TEMP_HI_I[2] | TEMP_LO_I[2]), 5'h00};
  assign st1_nxt = (st1_r & ~(rd_st1 ? ALL_ONES : RST_ZERO) & ~good1)
    | set1;
  assign st2_nxt = (st2_r & ~(rd_st2 ? ALL_ONES : RST_ZERO) & ~good2)
    | set2;

  // Hardware limit holds release only on a 5 degree return
  always_comb begin
    hw_hold_nxt = hw_hold_r;
    for (int c = 0; c < NUM_TEMP; c++) begin
      if (conv && hw_q[c]) begin
        hw_hold_nxt[c] = 1'b1;
      end else if (conv && TEMP_HW_OK_I[c]) begin
        hw_hold_nxt[c] = 1'b0;
      end
    end
  end

  // Alarm output; read release may re-arm, clear bit holds it off
  wire alarm_off = ~cfg1_r[C1_THERMAL_ALARM_N_EN] |
    cfg1_r[C1_THERMAL_ALARM_CLEAR];
  wire any_hold = |hw_hold_nxt;
  wire dflt_set = conv & |(t_q | hw_q);
  wire dflt_rel = (rd_st1 & ~any_hold) |
    (conv & ~|hi_q & ~any_hold);
  always_comb begin
    if (alarm_off) begin
      alarm_nxt = 1'b0;
    end else if (cfg2_r[C2_ACPI]) begin
      alarm_nxt = any_hold;
    end else if (dflt_set) begin
      alarm_nxt = 1'b1;
    end else if (dflt_rel) begin
      alarm_nxt = 1'b0;
    end else begin
      alarm_nxt = alarm_r;
    end
  end

  // Fan full on hardware hold or external alarm, mode regardless
  wire fan_full = any_hold | ext_low;

  // Hardware temperature interrupt ignores status reads
  wire hw_rel = cfg2_r[C2_THERMAL_ALARM_N_MASK] | cfg1_r[C1_INT_CLR] |
    ~cfg1_r[C1_INT_EN];
  assign hw_irq_nxt = (conv & |hw_q) | (hw_irq_r & ~hw_rel);

  // Interrupt request from unmasked status bits
  wire tmask = cfg2_r[C2_THERMAL_ALARM_N_MASK];
  wire [7:0] gate1 = ~msk1_r & ~(tmask ? THERMAL_BITS1 : RST_ZERO);
  wire [7:0] gate2 = ~msk2_r & ~(tmask ? THERMAL_BITS2 : RST_ZERO);
  wire src = |(st1_r & gate1) | |(st2_r & gate2) |
    (hw_irq_r & ~tmask);
  wire int_req = cfg1_r[C1_INT_EN] & ~cfg1_r[C1_INT_CLR] & src;
  wire alert_mode = alert_r[AL_ENABLE];
  wire int_drive = int_req &
    ~(alert_mode & (ara_done_r | ARA_ACK_I));

  // Reset pin sequencer
  wire pulse_end = (rp_state_r == RP_PULSE) &&
    (rp_cnt_r == 32'(RST_PULSE_CYCLES - 1));
  wire pulsing = (rp_state_r == RP_PULSE) && !pulse_end;
  wire soft_rst = (rp_state_r == RP_IDLE) && !reset_pin_s;
  always_comb begin
    case (rp_state_r)
      RP_IDLE: rp_state_nxt = cfg1_r[C1_RST_PULSE] ? RP_PULSE : RP_IDLE;
      RP_PULSE: rp_state_nxt = pulse_end ? RP_RECOVER : RP_PULSE;
      RP_RECOVER: rp_state_nxt =
        (rp_cnt_r == 32'(RECOVER_CYC - 1)) ? RP_IDLE : RP_RECOVER;
      default: rp_state_nxt = RP_IDLE;
    endcase
  end

  // Config 1: pulse bit held while pulsing, dropped at the end
  wire [7:0] cfg1_base = (wr_ok & hit_cfg1) ? PWDATA_I[7:0] : cfg1_r;
  wire [7:0] rp_bit = 8'(1) << C1_RST_PULSE;
  assign cfg1_nxt = pulsing ? (cfg1_base | rp_bit) :
    pulse_end ? (cfg1_base & ~rp_bit) : cfg1_base;

  // Sequencer state and counter
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rp_state_r <= RP_IDLE;
      rp_cnt_r <= 32'h0000_0000;
    end else if (CE_I) begin
      rp_state_r <= rp_state_nxt;
      rp_cnt_r <= (rp_state_nxt != rp_state_r) ? 32'h0000_0000 :
        rp_cnt_r + 32'h0000_0001;
    end
  end

  // Software registers; a low reset pin in RP_IDLE restores every default
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg1_r <= RST_CFG1;
      cfg2_r <= RST_ZERO;
      msk1_r <= RST_ZERO;
      msk2_r <= RST_ZERO;
      alert_r <= RST_ALERT;
      st1_r <= RST_ZERO;
      st2_r <= RST_ZERO;
    end else if (CE_I) begin
      if (soft_rst) begin
        cfg1_r <= RST_CFG1;
        cfg2_r <= RST_ZERO;
        msk1_r <= RST_ZERO;
        msk2_r <= RST_ZERO;
        alert_r <= RST_ALERT;
        st1_r <= RST_ZERO;
        st2_r <= RST_ZERO;
      end else begin
        cfg1_r <= cfg1_nxt;
        if (wr_ok && hit_cfg2) cfg2_r <= PWDATA_I[7:0];
        if (wr_ok && hit_msk1) msk1_r <= PWDATA_I[7:0];
        if (wr_ok && hit_msk2) msk2_r <= PWDATA_I[7:0];
        if (wr_ok && hit_alert) alert_r <= PWDATA_I[7:0];
        st1_r <= st1_nxt;
        st2_r <= st2_nxt;
      end
    end
  end

  // Alarm, hold and interrupt state
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      alarm_r <= 1'b0;
      alarm_d_r <= 2'b00;
      ext_low_d_r <= 1'b0;
      hw_hold_r <= '0;
      hw_irq_r <= 1'b0;
      ara_done_r <= 1'b0;
    end else if (CE_I) begin
      alarm_r <= alarm_nxt & ~soft_rst;
      alarm_d_r <= {alarm_d_r[0], alarm_r}; // Covers synchroniser lag
      ext_low_d_r <= ext_low;
      hw_hold_r <= hw_hold_nxt;
      hw_irq_r <= hw_irq_nxt & ~soft_rst;
      ara_done_r <= int_req &
        (ara_done_r | (ARA_ACK_I & alert_mode));
    end
  end

  // Tree test strap caught after the synchroniser has filled
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      strap_cnt_r <= 2'b00;
      strap_done_r <= 1'b0;
      tree_r <= 1'b0;
    end else if (CE_I) begin
      if (!strap_done_r) begin
        strap_cnt_r <= 2'(strap_cnt_r + 1'b1);
        if (strap_cnt_r == 2'(STRAP_WAIT - 1)) begin
          strap_done_r <= 1'b1;
          tree_r <= strap_s;
        end
      end else if (acc_done) begin
        tree_r <= 1'b0;
      end
    end
  end

  // Pin and status outputs, all from flops
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      drive_low_r <= 1'b0;
      INT_N_OE_N_O <= 1'b1;
      THERMAL_ALARM_N_OE_N_O <= 1'b1;
      RESET_N_OE_N_O <= 1'b1;
      FAN_DAC_OUT_FULL_O <= 1'b0;
      LOOP_RUN_O <= 1'b0;
      ALERT_PENDING_O <= 1'b0;
      TREE_MODE_O <= 1'b0;
    end else if (CE_I) begin
      drive_low_r <= 1'b0;
      INT_N_OE_N_O <= ~int_drive;
      THERMAL_ALARM_N_OE_N_O <= ~(alarm_nxt & ~soft_rst);
      RESET_N_OE_N_O <= ~pulsing;
      FAN_DAC_OUT_FULL_O <= fan_full;
      LOOP_RUN_O <= loop_run;
      ALERT_PENDING_O <= alert_mode & int_drive;
      TREE_MODE_O <= tree_r;
    end
  end

  // Open-drain pins only ever pull low
  assign INT_N_O = drive_low_r;
  assign THERMAL_ALARM_N_O = drive_low_r;
  assign RESET_N_O = drive_low_r;
endmodule // mita_top

// ===== verification/mita_asserts.sv
// Purpose: Port-level checks of the interrupt and alarm block
// Assumes: CE_I held high by the bench
// Notes: Bound to mita_top from the bench top file
`timescale 1ns/1ps
module mita_asserts #(
  parameter int RST_PULSE_CYCLES = 16
) (
  input wire logic REF_CLK_I, // Clock
  input wire logic RST_I, // Reset
  input wire logic PSEL_I, // Select
  input wire logic PENABLE_I, // Enable
  input wire logic [31:0] PRDATA_O, // Read data
  input wire logic PREADY_O, // Ready
  input wire logic PSLVERR_O, // Error
  input wire logic ARA_ACK_I, // Alert ack
  input wire logic THERMAL_ALARM_N_I, // Alarm line
  input wire logic THERMAL_ALARM_N_O, // Alarm value
  input wire logic THERMAL_ALARM_N_OE_N_O, // Alarm enable
  input wire logic INT_N_O, // Irq value
  input wire logic INT_N_OE_N_O, // Irq enable
  input wire logic RESET_N_OE_N_O, // Reset pin enable
  input wire logic FAN_DAC_OUT_FULL_O, // Fan full
  input wire logic LOOP_RUN_O, // Loop runs
  input wire logic ALERT_PENDING_O, // Alert owned
  input wire logic TREE_MODE_O // Tree test
);
  logic [31:0] low_r;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // Cycles the reset pin has been driven; a counter, as the pulse is long
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) low_r <= 32'h0000_0000;
    else if (RESET_N_OE_N_O) low_r <= 32'h0000_0000;
    else low_r <= low_r + 32'h0000_0001;
  end
  // Bus answer shape, then pin, pulse, fan, alert and tree checks
  a_ready_one_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held past one cycle");
  a_ready_after_access: assert property
    (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("no ready one cycle into access");
  a_error_with_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  a_clear_holds_irq: assert property (
    !LOOP_RUN_O && $past(!LOOP_RUN_O) |-> INT_N_OE_N_O)
    else $error("interrupt driven while line clear set");
  a_pins_drive_low: assert property (
    INT_N_O == 1'b0 && THERMAL_ALARM_N_O == 1'b0)
    else $error("open drain value not low");
  a_pulse_length: assert property (
    $rose(RESET_N_OE_N_O) |-> low_r == 32'(RST_PULSE_CYCLES - 1))
    else $error("reset pin pulse length wrong");
  a_outside_low_fan: assert property (
    (THERMAL_ALARM_N_OE_N_O && !THERMAL_ALARM_N_I)[*4]
    |-> FAN_DAC_OUT_FULL_O)
    else $error("outside alarm low did not force fan");
  a_alert_release: assert property (
    ALERT_PENDING_O && ARA_ACK_I |=> INT_N_OE_N_O)
    else $error("alert not released after ack");
  a_tree_leaves: assert property (
    TREE_MODE_O && PREADY_O |-> ##2 !TREE_MODE_O)
    else $error("tree mode kept after access");
  // Main scenarios reached
  c_pulse: cover property ($rose(RESET_N_OE_N_O));
  c_alert: cover property (ALERT_PENDING_O && ARA_ACK_I);
  c_error: cover property (PSLVERR_O);
endmodule // mita_asserts

// ===== verification/mita_partner.sv
// Purpose: Far side: pull-ups, outside drivers of pins, SMBus host
// Assumes: The host answers an alert by reading the response address
// Notes: Released open-drain lines float up to their pull-ups
`timescale 1ns/1ps
module mita_partner (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic al_n_i, // Alarm value
  input wire logic al_oe_n_i, // Alarm enable
  input wire logic in_n_i, // Irq value
  input wire logic in_oe_n_i, // Irq enable
  input wire logic rs_n_i, // Reset value
  input wire logic rs_oe_n_i, // Reset enable
  input wire logic pend_i, // Device owns alert
  input wire logic ext_al_i, // Pull alarm low
  input wire logic ext_rs_i, // Pull reset low
  input wire logic slow_i, // Late host
  output logic al_pin_o, // Alarm line
  output logic rs_pin_o, // Reset line
  output logic in_pin_o, // Irq line
  output logic ara_o // Ack of response
);
  logic [3:0] wait_r;
  // Wired-and of all drivers
  assign al_pin_o = (al_oe_n_i | al_n_i) & ~ext_al_i;
  assign rs_pin_o = (rs_oe_n_i | rs_n_i) & ~ext_rs_i;
  assign in_pin_o = in_oe_n_i | in_n_i;
  // Host turnaround after seeing the alert line low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) wait_r <= 4'h0;
    else if (in_pin_o || !pend_i) wait_r <= 4'h0;
    else if (wait_r != 4'hf) wait_r <= wait_r + 4'h1;
  end
  // Only an alerting device answers, once per alert
  assign ara_o = pend_i && wait_r == (slow_i ? 4'h9 : 4'h2);
endmodule // mita_partner

// ===== verification/testbench.sv
// Purpose: Self-checking bench of the interrupt and alarm block
// Assumes: Reset pulse shortened to 16 cycles; CE_I held high
// Notes: APB tasks reach the registers; far side in mita_partner
`timescale 1ns/1ps
module testbench;
  import mita_pkg::*;
  localparam int PULSE = 16;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h00000000;
  logic conv = 1'b0, strap = 1'b1, ext_al = 1'b0, ext_rs = 1'b0;
  logic slow = 1'b0;
  logic [9:0] vf = 10'h000;
  logic [2:0] thi = 3'h0, tlo = 3'h0, thw = 3'h0, tok = 3'h0;
  logic ara, al_pin, rs_pin, int_pin, al_n, al_oe, in_n, in_oe, rs_n;
  logic rs_oe, pready, perr, fan, loop_run, alert, tree, err;
  logic [31:0] prdata, q;
  logic [7:0] ridx [9] = '{IDX_CFG1, IDX_ST1, IDX_ST2, IDX_MSK1,
    IDX_MSK2, IDX_CFG2, IDX_MIR1, IDX_MIR2, IDX_ALERT};
  logic [7:0] rval [9] = '{RST_CFG1, RST_ZERO, RST_ZERO, RST_ZERO,
    RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ALERT};
  int fails = 0, n_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  mita_top #(.RST_PULSE_CYCLES(PULSE), .FAULT_DEPTH(3)) DUT (
    .REF_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
    .CONV_DONE_I(conv), .VF_OUT_I(vf), .TEMP_HI_I(thi), .TEMP_LO_I(tlo),
    .TEMP_HW_I(thw), .TEMP_HW_OK_I(tok), .ARA_ACK_I(ara),
    .THERMAL_ALARM_N_I(al_pin), .THERMAL_ALARM_N_O(al_n),
    .THERMAL_ALARM_N_OE_N_O(al_oe), .INT_N_O(in_n), .INT_N_OE_N_O(in_oe),
    .RESET_N_I(rs_pin), .RESET_N_O(rs_n), .RESET_N_OE_N_O(rs_oe),
    .DAC_PIN_TREE_IN_I(strap), .FAN_DAC_OUT_FULL_O(fan),
    .LOOP_RUN_O(loop_run), .ALERT_PENDING_O(alert), .TREE_MODE_O(tree));
  mita_partner u_far (.clk_i(clk), .rst_i(rst), .al_n_i(al_n),
    .al_oe_n_i(al_oe), .in_n_i(in_n), .in_oe_n_i(in_oe), .rs_n_i(rs_n),
    .rs_oe_n_i(rs_oe), .pend_i(alert), .ext_al_i(ext_al),
    .ext_rs_i(ext_rs), .slow_i(slow), .al_pin_o(al_pin),
    .rs_pin_o(rs_pin), .in_pin_o(int_pin), .ara_o(ara));
  // One APB transfer; held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= {2'b00, i, 2'b00};
    pwd <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    chk(q, {24'h000000, e});
  endtask
  // Pin level after flops and pin synchronisers have settled
  task automatic lvl(ref logic s, input logic e);
    repeat (5) @(posedge clk);
    chk({31'h0, s}, {31'h0, e});
  endtask
  // One conversion round; status reads spaced by a round see fresh bits
  task automatic cv();
    @(posedge clk);
    conv <= 1'b1;
    @(posedge clk);
    conv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far above the length of the sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("ERROR %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    lvl(tree, 1'b1);
    strap <= 1'b0;
    foreach (ridx[i]) rd(ridx[i], rval[i]);
    lvl(tree, 1'b0);
    rd(8'hff, 8'h00);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    wr(IDX_CFG1, 8'h02);
    vf <= 10'h3ff;
    cv();
    lvl(int_pin, 1'b0);
    rd(IDX_MIR1, 8'hcf);
    rd(IDX_MIR2, 8'h0f);
    rd(IDX_ST1, 8'hcf);
    rd(IDX_ST1, 8'h00);
    rd(IDX_ST2, 8'h0f);
    lvl(int_pin, 1'b1);
    vf <= 10'h001;
    wr(IDX_MSK1, 8'h01);
    cv();
    lvl(int_pin, 1'b1);
    rd(IDX_MIR1, 8'h01);
    wr(IDX_MSK1, 8'h00);
    lvl(int_pin, 1'b0);
    wr(IDX_CFG1, 8'h00);
    lvl(int_pin, 1'b1);
    wr(IDX_CFG1, 8'h0a);
    lvl(int_pin, 1'b1);
    rd(IDX_ST1, 8'h01);
    cv();
    rd(IDX_MIR1, 8'h00);
    lvl(loop_run, 1'b0);
    wr(IDX_CFG1, 8'h02);
    cv();
    vf <= 10'h000;
    rd(IDX_ST1, 8'h01);
    $display("test status done");
    ext_al <= 1'b1;
    lvl(fan, 1'b1);
    lvl(int_pin, 1'b0);
    rd(IDX_ST2, 8'h10);
    rd(IDX_ST2, 8'h00);
    cv();
    rd(IDX_MIR2, 8'h10);
    wr(IDX_CFG2, 8'h01);
    lvl(int_pin, 1'b1);
    cv();
    rd(IDX_ST2, 8'h10);
    ext_al <= 1'b0;
    wr(IDX_CFG2, 8'h00);
    wr(IDX_CFG1, 8'h06);
    thi <= 3'b001;
    cv();
    lvl(al_pin, 1'b0);
    ext_al <= 1'b1;
    cv();
    rd(IDX_MIR2, 8'h00);
    ext_al <= 1'b0;
    rd(IDX_ST1, 8'h10);
    lvl(al_pin, 1'b1);
    cv();
    lvl(al_pin, 1'b0);
    wr(IDX_CFG1, 8'h46);
    lvl(al_pin, 1'b1);
    cv();
    lvl(al_pin, 1'b1);
    thi <= 3'b000;
    wr(IDX_CFG1, 8'h06);
    cv();
    lvl(al_pin, 1'b1);
    rd(IDX_ST1, 8'h10);
    $display("test default alarm done");
    thw <= 3'b001;
    cv();
    lvl(fan, 1'b1);
    lvl(al_pin, 1'b0);
    rd(IDX_ST1, 8'h00);
    lvl(int_pin, 1'b0);
    wr(IDX_CFG1, 8'h46);
    lvl(al_pin, 1'b1);
    wr(IDX_CFG2, 8'h01);
    lvl(int_pin, 1'b1);
    lvl(fan, 1'b1);
    thw <= 3'b000;
    tok <= 3'b001;
    cv();
    lvl(fan, 1'b0);
    wr(IDX_CFG1, 8'h06);
    wr(IDX_CFG2, 8'h08);
    tlo <= 3'b001;
    cv();
    lvl(al_pin, 1'b1);
    rd(IDX_ST1, 8'h10);
    tlo <= 3'b000;
    thw <= 3'b001;
    tok <= 3'b000;
    cv();
    lvl(al_pin, 1'b0);
    lvl(fan, 1'b1);
    thw <= 3'b000;
    tok <= 3'b001;
    cv();
    lvl(al_pin, 1'b1);
    lvl(fan, 1'b0);
    wr(IDX_CFG1, 8'h0a);
    wr(IDX_CFG2, 8'h00);
    xfer(1'b0, IDX_ST1, 8'h00);
    wr(IDX_CFG1, 8'h02);
    $display("test hardware and acpi done");
    thi <= 3'b010;
    for (int i = 1; i <= 3; i++) begin
      cv();
      rd(IDX_MIR1, (i == 3) ? 8'h20 : 8'h00);
    end
    thi <= 3'b000;
    cv();
    rd(IDX_MIR1, 8'h00);
    wr(IDX_ALERT, 8'h60);
    rd(IDX_ALERT, 8'h60);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      vf <= 10'h001;
      cv();
      vf <= 10'h000;
      while (ara !== 1'b1) @(posedge clk);
      @(posedge clk);
      chk({31'h0, int_pin}, 32'h1);
      rd(IDX_ST1, 8'h01);
    end
    wr(IDX_ALERT, 8'h20);
    $display("test queue and alert done");
    wr(IDX_CFG1, 8'h12);
    lvl(rs_pin, 1'b0);
    repeat (PULSE + 4) @(posedge clk);
    rd(IDX_CFG1, 8'h02);
    wr(IDX_MSK1, 8'h55);
    ext_rs <= 1'b1;
    repeat (4) @(posedge clk);
    ext_rs <= 1'b0;
    repeat (4) @(posedge clk);
    rd(IDX_MSK1, 8'h00);
    rd(IDX_CFG1, 8'h08);
    $display("test reset pin done");
    give_verdict();
  end
endmodule // testbench
bind mita_top mita_asserts #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) u_chk (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .ARA_ACK_I(ARA_ACK_I),
  .THERMAL_ALARM_N_I(THERMAL_ALARM_N_I),
  .THERMAL_ALARM_N_O(THERMAL_ALARM_N_O),
  .THERMAL_ALARM_N_OE_N_O(THERMAL_ALARM_N_OE_N_O), .INT_N_O(INT_N_O),
  .INT_N_OE_N_O(INT_N_OE_N_O), .RESET_N_OE_N_O(RESET_N_OE_N_O),
  .FAN_DAC_OUT_FULL_O(FAN_DAC_OUT_FULL_O), .LOOP_RUN_O(LOOP_RUN_O),
  .ALERT_PENDING_O(ALERT_PENDING_O), .TREE_MODE_O(TREE_MODE_O));
